// [logic/fcc_flash_ctrl.sv]
// Purpose: Flash command controller with a two-stage command pipeline.
// Assumes: Mode and security inputs come from logic on clk_i; no synchronisers.
// Notes:   Program and erase times are counts of the divided timebase, verify steps one word per clock, array is flip-flops.
//
// The implementer's own choices: register access over Wishbone and the placing of the registers.

module fcc_flash_ctrl #(
   parameter logic [15:0] PROG_TICKS = 16'h0004,
   parameter logic [15:0] SECT_TICKS = 16'h0010,
   parameter logic [15:0] MASS_TICKS = 16'h0020
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   // Wishbone slave
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [fcc_pkg::FCC_AW-1:0] wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   // System mode and security
   input  wire logic                     wait_mode_i,
   input  wire logic                     stop_mode_i,
   input  wire logic                     debug_mode_i,
   input  wire logic                     secure_i,
   input  wire logic                     nonsecure_src_i,
   // Status toward the system
   output logic                          irq_o,
   output logic                          hv_on_o
);

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------

   // A low or high word is protected when its region has no disable, a middle word when the middle is closed.
   function automatic logic word_protected(input logic [fcc_pkg::FCC_IDX_W-1:0] idx,
                                           input logic [7:0] prot);
      logic low;
      logic high;
      low  = (32'(idx) < fcc_pkg::FCC_LOW_WORDS);
      high = (32'(idx) >= fcc_pkg::FCC_HIGH_START);
      if (low) begin
         word_protected = !prot[fcc_pkg::FCC_PROT_LDIS_BIT];
      end else if (high) begin
         word_protected = !prot[fcc_pkg::FCC_PROT_HDIS_BIT];
      end else begin
         word_protected = !prot[fcc_pkg::FCC_PROT_OPEN_BIT];
      end
   endfunction

   // Maps a command code onto an algorithm; unknown codes map to none.
   function automatic fcc_pkg::fcc_op_type decode_cmd(input logic [7:0] code);
      case (code)
         fcc_pkg::FCC_CMD_VERIFY:  decode_cmd = fcc_pkg::OP_VERIFY;
         fcc_pkg::FCC_CMD_PROGRAM: decode_cmd = fcc_pkg::OP_PROG;
         fcc_pkg::FCC_CMD_SECTOR:  decode_cmd = fcc_pkg::OP_SECT;
         fcc_pkg::FCC_CMD_MASS:    decode_cmd = fcc_pkg::OP_MASS;
         default:                  decode_cmd = fcc_pkg::OP_NONE;
      endcase
   endfunction

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   fcc_pkg::fcc_state_type s_ff;
   fcc_pkg::fcc_state_type nxt_s;

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------

   // Bus writes are handled first so that engine and stop events, which come later,
   // win over a software clear in the same cycle.
   always_comb begin
      logic                         hit;
      logic                         tick;
      logic                         done;
      logic                         err;
      logic [7:0]                   off;
      logic [fcc_pkg::FCC_IDX_W-1:0] idx;
      fcc_pkg::fcc_op_type          op;
      logic                         prot_bad;
      hit      = wb_cyc_i && wb_stb_i && !s_ff.ack;
      tick     = 1'b0;
      done     = 1'b0;
      err      = 1'b0;
      off      = wb_adr_i[7:0];
      idx      = wb_adr_i[fcc_pkg::FCC_IDX_W+1:2];
      op       = fcc_pkg::OP_NONE;
      prot_bad = 1'b0;
      nxt_s    = s_ff;
      nxt_s.ack = hit;

      // Divided timebase: one tick every div+1 bus clocks.
      if (s_ff.divcnt >= s_ff.div) begin
         nxt_s.divcnt = '0;
         tick         = 1'b1;
      end else begin
         nxt_s.divcnt = s_ff.divcnt + 7'h01;
      end

      // Register reads have no side effects.
      if (hit && !wb_we_i) begin
         nxt_s.rdat = '0;
         if (wb_adr_i[fcc_pkg::FCC_ARRAY_SEL]) begin
            if (s_ff.active != fcc_pkg::OP_NONE) begin
               nxt_s.rdat[15:0] = fcc_pkg::FCC_INVALID_DATA;
            end else begin
               nxt_s.rdat[15:0] = s_ff.mem[idx];
            end
         end else begin
            case (off)
               fcc_pkg::FCC_OFF_DIV: begin
                  nxt_s.rdat[6:0] = s_ff.div;
                  nxt_s.rdat[fcc_pkg::FCC_DIV_LD_BIT] = s_ff.divld;
               end
               fcc_pkg::FCC_OFF_CFG: begin
                  nxt_s.rdat[fcc_pkg::FCC_CFG_BUFFER_EMPTY_INT_ENABLE_BIT] = s_ff.buffer_empty_int_enable;
                  nxt_s.rdat[fcc_pkg::FCC_CFG_COMPLETE_INT_ENABLE_BIT]  = s_ff.complete_int_enable;
               end
               fcc_pkg::FCC_OFF_PROT: nxt_s.rdat[7:0] = s_ff.prot;
               fcc_pkg::FCC_OFF_STATUS: begin
                  nxt_s.rdat[fcc_pkg::FCC_ST_BUFFER_EMPTY_FLAG_BIT]  = s_ff.buffer_empty_flag;
                  nxt_s.rdat[fcc_pkg::FCC_ST_COMMAND_COMPLETE_FLAG_BIT]   = s_ff.command_complete_flag;
                  nxt_s.rdat[fcc_pkg::FCC_ST_PROTECTION_VIOLATION_FLAG_BIT]  = s_ff.protection_violation_flag;
                  nxt_s.rdat[fcc_pkg::FCC_ST_ACCESS_ERROR_FLAG_BIT] = s_ff.access_error_flag;
                  nxt_s.rdat[fcc_pkg::FCC_ST_BLANK_BIT]  = s_ff.blank;
               end
               fcc_pkg::FCC_OFF_CMD: nxt_s.rdat[7:0] = s_ff.bcmd;
               default: nxt_s.rdat = '0;
            endcase
         end
      end

      // Writes: array word, register, or a step of the command sequence.
      if (hit && wb_we_i) begin
         if (wb_adr_i[fcc_pkg::FCC_ARRAY_SEL]) begin
            if (!s_ff.divld || wb_sel_i != fcc_pkg::FCC_SEL_WORD || !s_ff.buffer_empty_flag) begin
               err = 1'b1;
            end else if (s_ff.seq != fcc_pkg::SEQ_IDLE) begin
               err = 1'b1;
            end else begin
               nxt_s.seq   = fcc_pkg::SEQ_ADDR;
               nxt_s.baddr = idx;
               nxt_s.bdata = wb_dat_i[15:0];
            end
         end else begin
            // Flag clears come before the sequence steps, so that a violation or error
            // raised by this same write still wins over the clear.
            if (off == fcc_pkg::FCC_OFF_STATUS) begin
               if (wb_dat_i[fcc_pkg::FCC_ST_PROTECTION_VIOLATION_FLAG_BIT]) begin
                  nxt_s.protection_violation_flag = 1'b0;
               end
               if (wb_dat_i[fcc_pkg::FCC_ST_ACCESS_ERROR_FLAG_BIT]) begin
                  nxt_s.access_error_flag = 1'b0;
               end
            end
            case (s_ff.seq)
               fcc_pkg::SEQ_ADDR: begin
                  op = decode_cmd(wb_dat_i[7:0]);
                  if (off != fcc_pkg::FCC_OFF_CMD || op == fcc_pkg::OP_NONE) begin
                     err = 1'b1;
                  end else if (secure_i && op != fcc_pkg::OP_MASS
                               && (nonsecure_src_i || debug_mode_i)) begin
                     err = 1'b1;
                  end else begin
                     nxt_s.bcmd = wb_dat_i[7:0];
                     nxt_s.seq  = fcc_pkg::SEQ_CMD;
                  end
               end
               fcc_pkg::SEQ_CMD: begin
                  if (off != fcc_pkg::FCC_OFF_STATUS) begin
                     err = 1'b1;
                  end else if (!wb_dat_i[fcc_pkg::FCC_ST_BUFFER_EMPTY_FLAG_BIT]) begin
                     err = 1'b1;
                  end else begin
                     nxt_s.seq = fcc_pkg::SEQ_IDLE;
                     op        = decode_cmd(s_ff.bcmd);
                     case (op)
                        fcc_pkg::OP_PROG: prot_bad = word_protected(s_ff.baddr, s_ff.prot);
                        fcc_pkg::OP_SECT: begin
                           prot_bad = word_protected({s_ff.baddr[fcc_pkg::FCC_SECT_LSB],
                                                      8'h00}, s_ff.prot)
                                   || word_protected({s_ff.baddr[fcc_pkg::FCC_SECT_LSB],
                                                      8'hFF}, s_ff.prot);
                        end
                        fcc_pkg::OP_MASS: prot_bad = (s_ff.prot[fcc_pkg::FCC_PROT_OPEN_BIT]
                                   & s_ff.prot[fcc_pkg::FCC_PROT_HDIS_BIT]
                                   & s_ff.prot[fcc_pkg::FCC_PROT_LDIS_BIT]) == 1'b0;
                        default: prot_bad = 1'b0;
                     endcase
                     if (s_ff.access_error_flag || s_ff.protection_violation_flag) begin
                        nxt_s.seq = fcc_pkg::SEQ_IDLE;
                     end else if (!s_ff.divld) begin
                        err = 1'b1;
                     end else if (prot_bad) begin
                        nxt_s.protection_violation_flag = 1'b1;
                     end else begin
                        nxt_s.pend  = 1'b1;
                        nxt_s.paddr = s_ff.baddr;
                        nxt_s.pdata = s_ff.bdata;
                        nxt_s.pcmd  = s_ff.bcmd;
                        nxt_s.command_complete_flag  = 1'b0;
                        nxt_s.buffer_empty_flag = 1'b0;
                     end
                  end
               end
               default: begin
                  case (off)
                     fcc_pkg::FCC_OFF_DIV: begin
                        nxt_s.div   = wb_dat_i[6:0];
                        nxt_s.divld = 1'b1;
                     end
                     fcc_pkg::FCC_OFF_CFG: begin
                        nxt_s.buffer_empty_int_enable = wb_dat_i[fcc_pkg::FCC_CFG_BUFFER_EMPTY_INT_ENABLE_BIT];
                        nxt_s.complete_int_enable  = wb_dat_i[fcc_pkg::FCC_CFG_COMPLETE_INT_ENABLE_BIT];
                     end
                     fcc_pkg::FCC_OFF_PROT: begin
                        if (debug_mode_i) begin
                           nxt_s.prot = wb_dat_i[7:0];
                        end
                     end
                     fcc_pkg::FCC_OFF_CMD: err = 1'b1;
                     default: nxt_s.seq = fcc_pkg::SEQ_IDLE;
                  endcase
               end
            endcase
         end
         if (err) begin
            nxt_s.access_error_flag = 1'b1;
            nxt_s.seq    = fcc_pkg::SEQ_IDLE;
         end
      end

      // Algorithm engine; runs on in wait mode, so commands still complete there.
      case (s_ff.active)
         fcc_pkg::OP_VERIFY: begin
            if (s_ff.mem[s_ff.cnt[fcc_pkg::FCC_IDX_W-1:0]] != fcc_pkg::FCC_ERASED) begin
               nxt_s.blank = 1'b0;
               done        = 1'b1;
            end else if (32'(s_ff.cnt) == fcc_pkg::FCC_WORDS - 1) begin
               nxt_s.blank = 1'b1;
               done        = 1'b1;
            end else begin
               nxt_s.cnt = s_ff.cnt + 16'h0001;
            end
         end
         fcc_pkg::OP_PROG: begin
            if (tick && s_ff.cnt >= PROG_TICKS - 16'h0001) begin
               nxt_s.mem[s_ff.aaddr] = s_ff.mem[s_ff.aaddr] & s_ff.adata;
               done = 1'b1;
            end else if (tick) begin
               nxt_s.cnt = s_ff.cnt + 16'h0001;
            end
         end
         fcc_pkg::OP_SECT: begin
            if (tick && s_ff.cnt >= SECT_TICKS - 16'h0001) begin
               for (int i = 0; i < fcc_pkg::FCC_WORDS; i++) begin
                  if (i[fcc_pkg::FCC_SECT_LSB] == s_ff.aaddr[fcc_pkg::FCC_SECT_LSB]) begin
                     nxt_s.mem[i] = fcc_pkg::FCC_ERASED;
                  end
               end
               done = 1'b1;
            end else if (tick) begin
               nxt_s.cnt = s_ff.cnt + 16'h0001;
            end
         end
         fcc_pkg::OP_MASS: begin
            if (tick && s_ff.cnt >= MASS_TICKS - 16'h0001) begin
               for (int i = 0; i < fcc_pkg::FCC_WORDS; i++) begin
                  nxt_s.mem[i] = fcc_pkg::FCC_ERASED;
               end
               done = 1'b1;
            end else if (tick) begin
               nxt_s.cnt = s_ff.cnt + 16'h0001;
            end
         end
         default: done = 1'b0;
      endcase

      // Finishing: high voltage stays up only while more work is buffered.
      if (done) begin
         nxt_s.active = fcc_pkg::OP_NONE;
         nxt_s.hv     = nxt_s.pend;
         if (!nxt_s.pend) begin
            nxt_s.command_complete_flag = 1'b1;
         end
      end

      // A buffered command starts once the engine is idle, freeing the buffer.
      if (nxt_s.active == fcc_pkg::OP_NONE && nxt_s.pend) begin
         op           = decode_cmd(nxt_s.pcmd);
         nxt_s.active = op;
         nxt_s.aaddr  = nxt_s.paddr;
         nxt_s.adata  = nxt_s.pdata;
         nxt_s.cnt    = '0;
         nxt_s.hv     = (op != fcc_pkg::OP_VERIFY);
         nxt_s.pend   = 1'b0;
         nxt_s.buffer_empty_flag  = 1'b1;
         if (op == fcc_pkg::OP_VERIFY) begin
            nxt_s.blank = 1'b0;
         end
      end

      // Stop entry kills everything in flight; stop exit reopens the buffer.
      nxt_s.stopped = stop_mode_i;
      if (stop_mode_i && !s_ff.stopped
          && (s_ff.active != fcc_pkg::OP_NONE || s_ff.pend)) begin
         nxt_s.active = fcc_pkg::OP_NONE;
         nxt_s.pend   = 1'b0;
         nxt_s.hv     = 1'b0;
         nxt_s.command_complete_flag   = 1'b1;
         nxt_s.access_error_flag = 1'b1;
         nxt_s.seq    = fcc_pkg::SEQ_IDLE;
      end
      if (!stop_mode_i && s_ff.stopped) begin
         nxt_s.buffer_empty_flag = 1'b1;
         nxt_s.pend  = 1'b0;
      end

      // Interrupt request also serves as the wake-up from wait mode.
      nxt_s.irq = (nxt_s.buffer_empty_flag && nxt_s.buffer_empty_int_enable)
               || (nxt_s.command_complete_flag && nxt_s.complete_int_enable);

      // Reset aborts any command but keeps the array, which models non-volatile cells.
      if (rst_i) begin
         nxt_s        = '0;
         nxt_s.mem    = s_ff.mem;
         nxt_s.seq    = fcc_pkg::SEQ_IDLE;
         nxt_s.active = fcc_pkg::OP_NONE;
         nxt_s.div    = fcc_pkg::FCC_DIV_RESET;
         nxt_s.prot   = fcc_pkg::FCC_PROT_RESET;
         nxt_s.buffer_empty_flag  = 1'b1;
         nxt_s.command_complete_flag   = 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------

   // Single register stage for the whole block; reset is folded into nxt_s.
   always_ff @(posedge clk_i) begin
      s_ff <= nxt_s;
   end

   // Outputs come straight from the state register.
   assign wb_ack_o = s_ff.ack;
   assign wb_dat_o = s_ff.rdat;
   assign irq_o    = s_ff.irq;
   assign hv_on_o  = s_ff.hv;

endmodule

// [logic/fcc_pkg.sv]
// Purpose: Shared constants and types of the flash command controller.
// Assumes: Classic Wishbone slave with 32-bit data, one register per aligned word.
// Notes:   The flash array is a behavioural flip-flop model of 16-bit words.
package fcc_pkg;

   // -----------------------------------------------------------------
   // Register map and address decode
   // -----------------------------------------------------------------
   localparam int         FCC_AW           = 16;
   localparam int         FCC_ARRAY_SEL    = 15;     // Address bit that selects the array.
   localparam logic [7:0] FCC_OFF_DIV      = 8'h00;
   localparam logic [7:0] FCC_OFF_CFG      = 8'h04;
   localparam logic [7:0] FCC_OFF_PROT     = 8'h08;
   localparam logic [7:0] FCC_OFF_STATUS   = 8'h0C;
   localparam logic [7:0] FCC_OFF_CMD      = 8'h10;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int FCC_CFG_BUFFER_EMPTY_INT_ENABLE_BIT  = 7;
   localparam int FCC_CFG_COMPLETE_INT_ENABLE_BIT   = 6;
   localparam int FCC_DIV_LD_BIT     = 7;
   localparam int FCC_ST_BUFFER_EMPTY_FLAG_BIT   = 7;
   localparam int FCC_ST_COMMAND_COMPLETE_FLAG_BIT    = 6;
   localparam int FCC_ST_PROTECTION_VIOLATION_FLAG_BIT   = 5;
   localparam int FCC_ST_ACCESS_ERROR_FLAG_BIT  = 4;
   localparam int FCC_ST_BLANK_BIT   = 2;
   localparam int FCC_PROT_OPEN_BIT  = 7;
   localparam int FCC_PROT_HDIS_BIT  = 5;
   localparam int FCC_PROT_LDIS_BIT  = 2;

   // -----------------------------------------------------------------
   // Array geometry
   // -----------------------------------------------------------------
   localparam int FCC_IDX_W      = 9;
   localparam int FCC_WORDS      = 512;
   localparam int FCC_SECT_LSB   = 8;      // 512-byte sector is 256 words.
   localparam int FCC_LOW_WORDS  = 128;    // Size of the low protected region.
   localparam int FCC_HIGH_START = 384;    // First word of the high protected region.

   // -----------------------------------------------------------------
   // Command codes and constant values
   // -----------------------------------------------------------------
   localparam logic [7:0]  FCC_CMD_VERIFY   = 8'h05;
   localparam logic [7:0]  FCC_CMD_PROGRAM  = 8'h20;
   localparam logic [7:0]  FCC_CMD_SECTOR   = 8'h40;
   localparam logic [7:0]  FCC_CMD_MASS     = 8'h41;
   localparam logic [15:0] FCC_ERASED       = 16'hFFFF;
   localparam logic [15:0] FCC_INVALID_DATA = 16'h0000;
   localparam logic [3:0]  FCC_SEL_WORD     = 4'h3;
   localparam logic [7:0]  FCC_PROT_RESET   = 8'hFF;
   localparam logic [6:0]  FCC_DIV_RESET    = 7'h00;

   // -----------------------------------------------------------------
   // Types
   // -----------------------------------------------------------------
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_ADDR, SEQ_CMD} fcc_seq_type;
   typedef enum logic [2:0] {OP_NONE, OP_VERIFY, OP_PROG, OP_SECT, OP_MASS} fcc_op_type;

   typedef struct packed {
      logic                             ack;
      logic [31:0]                      rdat;
      logic                             irq;
      logic [6:0]                       div;
      logic                             divld;
      logic [6:0]                       divcnt;
      logic                             buffer_empty_int_enable;
      logic                             complete_int_enable;
      logic [7:0]                       prot;
      logic                             buffer_empty_flag;
      logic                             command_complete_flag;
      logic                             protection_violation_flag;
      logic                             access_error_flag;
      logic                             blank;
      fcc_seq_type                      seq;
      logic [FCC_IDX_W-1:0]             baddr;
      logic [15:0]                      bdata;
      logic [7:0]                       bcmd;
      logic                             pend;
      logic [FCC_IDX_W-1:0]             paddr;
      logic [15:0]                      pdata;
      logic [7:0]                       pcmd;
      fcc_op_type                       active;
      logic [FCC_IDX_W-1:0]             aaddr;
      logic [15:0]                      adata;
      logic [15:0]                      cnt;
      logic                             hv;
      logic                             stopped;
      logic [FCC_WORDS-1:0][15:0]       mem;
   } fcc_state_type;

endpackage

// [dv/fcc_flash_ctrl_assertions.sv]
// Purpose: Port checks of the flash command controller.
// Assumes: The timebase divider stays at zero, so every algorithm is short.
// Notes:   Bound to every instance of the controller.
module fcc_chk (
   // Watched ports.
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [15:0] wb_adr_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        stop_mode_i,
   input wire logic        hv_on_o
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // A taken request is answered one edge later, for one cycle only.
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
   AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack unasked");
   AST_DAT_HIGH: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000) else $error("dat");
   // Array reads while high voltage runs must not leak half-written data.
   AST_BUSY_READ: assert property (
      wb_cyc_i && wb_stb_i && !wb_we_i && wb_adr_i[15] && hv_on_o && !wb_ack_o
      |=> wb_dat_o == 32'h0000_0000) else $error("busy read");
   AST_STOP_HV: assert property ($rose(stop_mode_i) |-> ##[1:2] !hv_on_o)
      else $error("stop hv");
   AST_STOP_HOLD: assert property (stop_mode_i [*3] |-> !hv_on_o) else $error("hv in stop");
   AST_HV_BOUND: assert property ($rose(hv_on_o) |-> ##[1:1000] !hv_on_o)
      else $error("hv stuck");
   AST_RST_QUIET: assert property (disable iff (1'b0) rst_i |=> !hv_on_o && !wb_ack_o)
      else $error("reset");
   CVR_BUSY: cover property (hv_on_o && wb_ack_o);
   CVR_STOP: cover property (hv_on_o && stop_mode_i);
   CVR_READ: cover property (wb_ack_o && !wb_we_i);
endmodule

bind fcc_flash_ctrl fcc_chk chk_u (.*);

// [dv/fcc_host_model.sv]
// Purpose: Bus master standing in for the processor core.
// Assumes: The slave answers within 64 clocks.
// Notes:   Strobe is tied to cycle by the bench; ok is low after a hung cycle.
module fcc_host_model (
   // Clock.
   input  wire logic        clk_i,
   // Wishbone master side.
   output logic             cyc_o,
   output logic             we_o,
   output logic [15:0]      adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i
);
   timeunit 1ns;
   timeprecision 100ps;
   initial {cyc_o, we_o, adr_o, sel_o, dat_o} = '0;
   // One classic cycle; nothing moves until ack is sampled at an edge.
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                       input logic [3:0] s, output logic [31:0] q, output bit ok);
      ok = 1'b0;
      @(posedge clk_i);
      {cyc_o, we_o, adr_o, dat_o, sel_o} <= {1'b1, w, a, d, s};
      for (int n = 0; n < 64 && !ok; n++) begin
         @(posedge clk_i);
         ok = ack_i;
      end
      q = dat_i;
      cyc_o <= 1'b0;
   endtask
endmodule

// [dv/fcc_flash_ctrl_bench.sv]
// Purpose: Self-checking bench of the flash command controller.
// Assumes: Divider zero, so one timebase tick per clock.
// Notes:   The array is not reset, so a mass erase is the first command that runs.
module fcc_flash_ctrl_bench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [15:0] ST = 16'h000C;
   localparam logic [15:0] W5 = 16'h8014;
   logic        clk_i = 1'b0, rst_i = 1'b1, wt = 1'b0, stp = 1'b0, dbg = 1'b0;
   logic        sec = 1'b0, nsrc = 1'b0;
   logic        cyc, we, ack, irq, hv;
   logic [15:0] adr;
   logic [3:0]  sel;
   logic [31:0] wd, rd;
   int          miscompares = 0, n_tests = 0;
   always #2.5 clk_i = ~clk_i;
   fcc_flash_ctrl dut_u (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
      .wait_mode_i(wt), .stop_mode_i(stp), .debug_mode_i(dbg), .secure_i(sec),
      .nonsecure_src_i(nsrc), .irq_o(irq), .hv_on_o(hv));
   fcc_host_model host_u (.clk_i, .cyc_o(cyc), .we_o(we), .adr_o(adr), .sel_o(sel),
      .dat_o(wd), .ack_i(ack), .dat_i(rd));
   task automatic chk(input logic [31:0] got, exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("FAIL %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic test_done();
      $display("compares %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // A hung cycle ends the run at once.
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
      bit ok;
      host_u.xfer(w, a, d, s, q, ok);
      if (!ok) begin
         miscompares++;
         test_done();
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 4'hF, q);
   endtask
   task automatic rc(input logic [15:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 4'hF, q);
      chk(q, e);
   endtask
   // Array word, command code, then the buffer-empty write given in l.
   task automatic ln(input logic [8:0] w, input logic [15:0] d, input logic [7:0] c, l);
      logic [31:0] q;
      bus(1'b1, {5'h10, w, 2'h0}, {16'h0, d}, 4'h3, q);
      wr(16'h0010, {24'h0, c});
      wr(ST, {24'h0, l});
   endtask
   // Polls the complete flag; a limit that runs out is a mismatch.
   task automatic wc();
      logic [31:0] q;
      for (int n = 0; n < 200; n++) begin
         bus(1'b0, ST, 32'h0, 4'hF, q);
         if (q[6] === 1'b1) return;
      end
      miscompares++;
      test_done();
   endtask
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      rc(ST, 32'hC0);
      ln(9'h0, 16'h0, 8'h20, 8'h80);
      rc(ST, 32'hD0);
      wr(ST, 32'h30);
      wr(16'h0000, 32'h0);
      rc(16'h0000, 32'h80);
      ln(9'h0, 16'h0, 8'h41, 8'h80);
      wc();
      rc(W5, 32'hFFFF);
      ln(9'h3, 16'h0, 8'h05, 8'h80);
      wc();
      rc(ST, 32'hC4);
      wr(16'h0004, 32'h40);
      rc(16'h0004, 32'h40);
      @(posedge clk_i) wt <= 1'b1;
      ln(9'h5, 16'h1234, 8'h20, 8'h80);
      chk(irq, 32'h0);
      rc(W5, 32'h0);
      wc();
      chk(irq, 32'h1);
      wt <= 1'b0;
      rc(W5, 32'h1234);
      ln(9'h3, 16'h0, 8'h05, 8'h80);
      wc();
      rc(ST, 32'hC0);
      ln(9'h0FF, 16'h0, 8'h40, 8'h80);
      wc();
      rc(W5, 32'hFFFF);
      ln(9'h5, 16'h0, 8'h33, 8'h80);
      rc(ST, 32'hD0);
      ln(9'h5, 16'h0, 8'h20, 8'h80);
      rc(W5, 32'hFFFF);
      wr(ST, 32'h30);
      ln(9'h5, 16'h0, 8'h20, 8'h00);
      rc(ST, 32'hD0);
      wr(ST, 32'h30);
      @(posedge clk_i) dbg <= 1'b1;
      wr(16'h0008, 32'h0);
      ln(9'h5, 16'h0, 8'h20, 8'h80);
      rc(ST, 32'hE0);
      wr(ST, 32'h30);
      ln(9'h0, 16'h0, 8'h41, 8'h80);
      rc(ST, 32'hE0);
      wr(16'h0008, 32'hFF);
      wr(ST, 32'h30);
      ln(9'h100, 16'h0, 8'h40, 8'h80);
      chk(hv, 32'h1);
      stp <= 1'b1;
      repeat (4) @(posedge clk_i);
      stp <= 1'b0;
      chk(hv, 32'h0);
      rc(ST, 32'hD0);
      wr(ST, 32'h10);
      // Secured, non-secure source: only mass erase may pass.
      {dbg, sec, nsrc} <= 3'b011;
      ln(9'h5, 16'h0, 8'h20, 8'h80);
      rc(ST, 32'hD0);
      wr(ST, 32'h30);
      ln(9'h0, 16'h0, 8'h41, 8'h80);
      wc();
      rc(ST, 32'hC0);
      // Reset in mid-command must drop high voltage and restore the idle status.
      ln(9'h0, 16'h0, 8'h41, 8'h80);
      chk(hv, 32'h1);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      chk(hv, 32'h0);
      rc(ST, 32'hC0);
      rc(16'h0000, 32'h0);
      test_done();
   end
endmodule
